// >>> logic/fre_pkg.sv
`default_nettype none
// ************************************************************
// ring endpoint constants and word layout
// ************************************************************
package fre_pkg;
	// field widths of one transported word
	localparam int unsigned SLOT_W     = 4;
	localparam int unsigned FPGA_W     = 4;
	localparam int unsigned REG_W      = 8;
	localparam int unsigned DATA_W     = 64;
	// buffer depth of the incoming and outgoing buffers
	localparam int unsigned FIFO_DEPTH = 8;
	// user devices on one card ring, the service node sits after them
	localparam int unsigned FPGA_COUNT = 8;
	// command encodings
	localparam logic CMD_WR = 1'h0;
	localparam logic CMD_RD = 1'h1;
	// wildcard values of the physical components
	localparam logic [SLOT_W-1:0] SLOT_ALL = 4'hF;
	localparam logic [FPGA_W-1:0] FPGA_ALL = 4'hF;
	// lowest slot and device index on the ring
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h0;
	localparam logic [FPGA_W-1:0] FPGA_FIRST = 4'h0;
	// origin register of words coming from the host
	localparam logic [REG_W-1:0] HOST_SRC_REG = 8'h00;

	// one element address record: slot, device, command, register
	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		logic [FPGA_W-1:0] fpga;
		logic              cmd;
		logic [REG_W-1:0]  rg;
	} fre_addr_t;

	// a whole word on the ring: target, origin, payload
	typedef struct packed {
		fre_addr_t         tgt;
		fre_addr_t         src;
		logic [DATA_W-1:0] data;
	} fre_frame_t;

	// what the user sees of a received word: no target slot or device
	typedef struct packed {
		fre_addr_t         src;
		logic              tgt_cmd;
		logic [REG_W-1:0]  tgt_rg;
		logic [DATA_W-1:0] data;
	} fre_rx_t;
endpackage
`default_nettype wire

// >>> logic/fre_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// small word memory with registered read data
// ************************************************************
module fre_mem #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          reset_i,
	// write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [W-1:0]  wr_data_i,
	// read port
	input  wire logic          rd_en_i,
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [W-1:0]  rd_data_o
);
	logic [W-1:0] mem_q [DEPTH];   // storage, no reset like a block memory

	// write side
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// read data register, cleared so the output is defined from reset
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

// >>> logic/fre_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// first-in first-out buffer over the word memory
// ************************************************************
module fre_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// filling side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// draining side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

	// whole state of the buffer
	typedef struct packed {
		logic [AW:0]   cnt;   // words held in memory
		logic [AW-1:0] wp;    // write pointer
		logic [AW-1:0] rp;    // read pointer
		logic          ov;    // output register holds a word
	} fre_fifo_st_t;

	fre_fifo_st_t q, d;
	logic         push;
	logic         pull;

	// pointer and count update
	always_comb begin
		d          = q;
		in_ready_o = (q.cnt != CNT_FULL);
		push       = in_valid_i && in_ready_o;
		pull       = (q.cnt != '0) && (!q.ov || out_ready_i);
		if (push) begin
			d.wp = q.wp + AW'(1);
		end
		if (pull) begin
			d.rp = q.rp + AW'(1);
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pull);
		// output stage refills on a read, empties when taken
		if (pull) begin
			d.ov = 1'b1;
		end else if (out_ready_i) begin
			d.ov = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_valid_o = q.ov;

	// storage with registered read
	fre_mem #(
		.W     (W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.wr_en_i   (push),
		.wr_addr_i (q.wp),
		.wr_data_i (in_data_i),
		.rd_en_i   (pull),
		.rd_addr_i (q.rp),
		.rd_data_o (out_data_o)
	);
endmodule
`default_nettype wire

// >>> logic/fre_endpoint.sv
// Notes on behaviour
// - every word carries target and origin address
// - slot indices start at zero, physical order
// - devices on a card numbered from zero
// - wildcard slot or device means all of them
// - user answers reads with the requested count
// - register field only names a stream
// - user never sees target slot and device
// - host words show write origin and register zero
// - one channel, words never overtake
// - 64 bit words arrive in written order
// - exactly one outgoing register per endpoint
// - incoming and outgoing registers are memory buffers
// - fixed routes, no load avoidance
// - unicast takes the shortest ring direction
// - broadcasts leave in both directions at once
// - host broadcast stops at the two middle devices
// - no device receives a broadcast twice
// - active reads request data, passive only consume
// - unsolicited writes to host are allowed
`timescale 1ns/1ps
`default_nettype none
module fre_endpoint #(
	parameter int unsigned FPGA_COUNT = fre_pkg::FPGA_COUNT,
	parameter int unsigned FIFO_DEPTH = fre_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              reset_i,
	// own position straps
	input  wire logic [fre_pkg::SLOT_W-1:0]        my_slot_i,
	input  wire logic [fre_pkg::FPGA_W-1:0]        my_fpga_i,
	// ring input travelling towards higher indices
	input  wire logic                              up_in_valid_i,
	output logic                                   up_in_ready_o,
	input  wire fre_pkg::fre_frame_t               up_in_frame_i,
	// ring input travelling towards lower indices
	input  wire logic                              dn_in_valid_i,
	output logic                                   dn_in_ready_o,
	input  wire fre_pkg::fre_frame_t               dn_in_frame_i,
	// ring output towards higher indices
	output logic                                   up_out_valid_o,
	input  wire logic                              up_out_ready_i,
	output fre_pkg::fre_frame_t                    up_out_frame_o,
	// ring output towards lower indices
	output logic                                   dn_out_valid_o,
	input  wire logic                              dn_out_ready_i,
	output fre_pkg::fre_frame_t                    dn_out_frame_o,
	// user receive side
	output logic                                   rx_valid_o,
	input  wire logic                              rx_ready_i,
	output logic [fre_pkg::SLOT_W-1:0]             rx_src_slot_o,
	output logic [fre_pkg::FPGA_W-1:0]             rx_src_fpga_o,
	output logic                                   rx_src_cmd_o,
	output logic [fre_pkg::REG_W-1:0]              rx_src_reg_o,
	output logic                                   rx_tgt_cmd_o,
	output logic [fre_pkg::REG_W-1:0]              rx_tgt_reg_o,
	output logic [fre_pkg::DATA_W-1:0]             rx_data_o,
	// user send side
	input  wire logic                              tx_valid_i,
	output logic                                   tx_ready_o,
	input  wire logic [fre_pkg::SLOT_W-1:0]        tx_tgt_slot_i,
	input  wire logic [fre_pkg::FPGA_W-1:0]        tx_tgt_fpga_i,
	input  wire logic                              tx_tgt_cmd_i,
	input  wire logic [fre_pkg::REG_W-1:0]         tx_tgt_reg_i,
	input  wire logic                              tx_src_cmd_i,
	input  wire logic [fre_pkg::REG_W-1:0]         tx_src_reg_i,
	input  wire logic [fre_pkg::DATA_W-1:0]        tx_data_i
);
	// ************************************************************
	// types and helpers
	// ************************************************************
	localparam int unsigned PW   = fre_pkg::FPGA_W + 1;   // ring position width
	localparam logic [PW-1:0] RING = PW'(FPGA_COUNT + 1); // users plus service node
	localparam logic [PW-1:0] SVC  = PW'(FPGA_COUNT);     // service node position
	localparam logic [PW-1:0] HALF = (RING - PW'(1)) >> 1; // hops covered upwards
	localparam logic [PW-1:0] REST = RING - PW'(1) - HALF; // hops covered downwards

	// whole state of the endpoint
	typedef struct packed {
		logic                          up_v;    // upward output register full
		fre_pkg::fre_frame_t           up_f;    // upward output word
		logic                          dn_v;    // downward output register full
		fre_pkg::fre_frame_t           dn_f;    // downward output word
		logic                          id_ok;   // straps captured
		logic [fre_pkg::SLOT_W-1:0]    slot;    // own slot index
		logic [fre_pkg::FPGA_W-1:0]    fpga;    // own device index
	} fre_ep_st_t;

	// hops from position a to position b going upwards
	function automatic logic [PW-1:0] fre_hops(input logic [PW-1:0] a, input logic [PW-1:0] b);
		fre_hops = (b >= a) ? (b - a) : (b + RING - a);
	endfunction

	// device on this card addressed by a target record
	function automatic logic fre_hit(input fre_pkg::fre_addr_t t,
	                                 input logic [fre_pkg::SLOT_W-1:0] s,
	                                 input logic [fre_pkg::FPGA_W-1:0] f);
		fre_hit = (t.slot == fre_pkg::SLOT_ALL || t.slot == s)
		       && (t.fpga == fre_pkg::FPGA_ALL || t.fpga == f);
	endfunction

	// ring position a word started from: own card device or service node
	function automatic logic [PW-1:0] fre_origin(input fre_pkg::fre_addr_t src,
	                                             input logic [fre_pkg::SLOT_W-1:0] s);
		fre_origin = (src.slot == s && PW'(src.fpga) < SVC) ? PW'(src.fpga) : SVC;
	endfunction

	fre_ep_st_t          q, d;
	logic [PW-1:0]       me;                   // own ring position
	logic                up_dlv, up_fwd;       // upward input: keep, pass on
	logic                dn_dlv, dn_fwd;       // downward input: keep, pass on
	logic                up_take, dn_take;     // input words accepted
	logic                up_free, dn_free;     // output registers can load
	logic                rxf_ready;            // incoming buffer has room
	logic                rxf_push;             // word written to incoming buffer
	fre_pkg::fre_frame_t rx_sel;               // word chosen for local delivery
	fre_pkg::fre_rx_t    rxf_in, rxf_out;      // buffer words
	logic                txf_valid, txf_take;  // outgoing buffer head
	fre_pkg::fre_frame_t txf_out;              // outgoing buffer head word
	fre_pkg::fre_frame_t tx_word;              // head word with origin stamped
	logic                tx_bcast, tx_up;      // send both ways, or upwards
	logic [PW-1:0]       tx_dest;              // ring position to head for

	assign me      = PW'(q.fpga);
	assign up_free = !q.up_v || up_out_ready_i;
	assign dn_free = !q.dn_v || dn_out_ready_i;

	// ************************************************************
	// routing decision for words arriving on the ring
	// ************************************************************
	always_comb begin
		up_dlv = fre_hit(up_in_frame_i.tgt, q.slot, q.fpga);
		dn_dlv = fre_hit(dn_in_frame_i.tgt, q.slot, q.fpga);
		// broadcast stops at the half-ring edge
		if (up_in_frame_i.tgt.fpga == fre_pkg::FPGA_ALL) begin
			up_fwd = fre_hops(fre_origin(up_in_frame_i.src, q.slot), me) < HALF;
		end else begin
			// unicast passes on until its target
			up_fwd = !(up_in_frame_i.tgt.slot == q.slot && up_in_frame_i.tgt.fpga == q.fpga);
		end
		if (dn_in_frame_i.tgt.fpga == fre_pkg::FPGA_ALL) begin
			dn_fwd = fre_hops(me, fre_origin(dn_in_frame_i.src, q.slot)) < REST;
		end else begin
			dn_fwd = !(dn_in_frame_i.tgt.slot == q.slot && dn_in_frame_i.tgt.fpga == q.fpga);
		end
	end

	// ************************************************************
	// acceptance and arbitration of the incoming buffer
	// ************************************************************
	always_comb begin
		up_in_ready_o = q.id_ok && (!up_dlv || rxf_ready) && (!up_fwd || up_free);
		dn_in_ready_o = q.id_ok && (!dn_dlv || rxf_ready) && (!dn_fwd || dn_free)
		             && !(up_in_valid_i && up_dlv && dn_dlv);
		up_take  = up_in_valid_i && up_in_ready_o;
		dn_take  = dn_in_valid_i && dn_in_ready_o;
		rxf_push = (up_take && up_dlv) || (dn_take && dn_dlv);
		rx_sel   = (up_take && up_dlv) ? up_in_frame_i : dn_in_frame_i;
		// only target slot and device dropped
		rxf_in.src     = rx_sel.src;
		rxf_in.tgt_cmd = rx_sel.tgt.cmd;
		rxf_in.tgt_rg  = rx_sel.tgt.rg;
		rxf_in.data    = rx_sel.data;
		// words from the host show write and register zero
		if (fre_origin(rx_sel.src, q.slot) == SVC) begin
			rxf_in.src.cmd = fre_pkg::CMD_WR;
			rxf_in.src.rg  = fre_pkg::HOST_SRC_REG;
		end
	end

	// ************************************************************
	// direction choice for the user's own words
	// ************************************************************
	always_comb begin
		// own origin stamped on every sent word
		tx_word          = txf_out;
		tx_word.src.slot = q.slot;
		tx_word.src.fpga = q.fpga;
		tx_bcast = (txf_out.tgt.fpga == fre_pkg::FPGA_ALL);
		// other cards are reached through the service node
		tx_dest = (txf_out.tgt.slot == q.slot) ? PW'(txf_out.tgt.fpga) : SVC;
		// shortest way round, ties go upwards
		tx_up = fre_hops(me, tx_dest) <= fre_hops(tx_dest, me);
		// a broadcast needs both output registers at once
		if (tx_bcast) begin
			txf_take = txf_valid && q.id_ok && up_free && dn_free
			        && !(up_take && up_fwd) && !(dn_take && dn_fwd);
		end else if (tx_up) begin
			txf_take = txf_valid && q.id_ok && up_free && !(up_take && up_fwd);
		end else begin
			txf_take = txf_valid && q.id_ok && dn_free && !(dn_take && dn_fwd);
		end
	end

	// ************************************************************
	// next state of the output registers and straps
	// ************************************************************
	always_comb begin
		d = q;
		// own indices taken once after reset
		if (!q.id_ok) begin
			d.id_ok = 1'b1;
			d.slot  = my_slot_i;
			d.fpga  = my_fpga_i;
		end
		// a loaded word stays until taken; passing traffic first
		if (up_free) begin
			d.up_v = 1'b0;
			if (up_take && up_fwd) begin
				d.up_v = 1'b1;
				d.up_f = up_in_frame_i;
			end else if (txf_take && (tx_bcast || tx_up)) begin
				d.up_v = 1'b1;
				d.up_f = tx_word;
			end
		end
		if (dn_free) begin
			d.dn_v = 1'b0;
			if (dn_take && dn_fwd) begin
				d.dn_v = 1'b1;
				d.dn_f = dn_in_frame_i;
			end else if (txf_take && (tx_bcast || !tx_up)) begin
				d.dn_v = 1'b1;
				d.dn_f = tx_word;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign up_out_valid_o = q.up_v;
	assign up_out_frame_o = q.up_f;
	assign dn_out_valid_o = q.dn_v;
	assign dn_out_frame_o = q.dn_f;

	// ************************************************************
	// incoming and outgoing buffers
	// ************************************************************
	// incoming register keeps arrival order
	fre_fifo #(
		.W     ($bits(fre_pkg::fre_rx_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (rxf_push),
		.in_ready_o  (rxf_ready),
		.in_data_i   (rxf_in),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i),
		.out_data_o  (rxf_out)
	);
	assign rx_src_slot_o = rxf_out.src.slot;
	assign rx_src_fpga_o = rxf_out.src.fpga;
	assign rx_src_cmd_o  = rxf_out.src.cmd;
	assign rx_src_reg_o  = rxf_out.src.rg;
	assign rx_tgt_cmd_o  = rxf_out.tgt_cmd;
	assign rx_tgt_reg_o  = rxf_out.tgt_rg;
	assign rx_data_o     = rxf_out.data;

	fre_fifo #(
		.W     ($bits(fre_pkg::fre_frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.in_data_i   ({tx_tgt_slot_i, tx_tgt_fpga_i, tx_tgt_cmd_i, tx_tgt_reg_i,
		               fre_pkg::SLOT_FIRST, fre_pkg::FPGA_FIRST, tx_src_cmd_i,
		               tx_src_reg_i, tx_data_i}),
		.out_valid_o (txf_valid),
		.out_ready_i (txf_take),
		.out_data_o  (txf_out)
	);

	// ************************************************************
	// checks
	// ************************************************************
	property p_no_drop;
		@(posedge clk_i) disable iff (reset_i)
		up_in_valid_i && up_dlv && !rxf_ready |-> !up_in_ready_o;
	endproperty
	a_no_drop: assert property (p_no_drop) else $error("ring word accepted into full buffer");

	property p_bcast_both;
		@(posedge clk_i) disable iff (reset_i)
		txf_take && tx_bcast |=> q.up_v && q.dn_v && q.up_f == q.dn_f;
	endproperty
	a_bcast_both: assert property (p_bcast_both) else $error("broadcast not sent both ways");

	property p_hold_out;
		@(posedge clk_i) disable iff (reset_i)
		q.up_v && !up_out_ready_i |=> q.up_v && $stable(q.up_f);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("waiting ring word changed");

	property p_stamp;
		@(posedge clk_i) disable iff (reset_i)
		txf_take && tx_up |=> q.up_f.src.slot == q.slot && q.up_f.src.fpga == q.fpga;
	endproperty
	a_stamp: assert property (p_stamp) else $error("sent word lacks own origin");

	property p_host_norm;
		@(posedge clk_i) disable iff (reset_i)
		rxf_push && fre_origin(rx_sel.src, q.slot) == SVC
		|-> rxf_in.src.cmd == fre_pkg::CMD_WR && rxf_in.src.rg == fre_pkg::HOST_SRC_REG;
	endproperty
	a_host_norm: assert property (p_host_norm) else $error("host word origin not normalised");

	property p_stop_at_target;
		@(posedge clk_i) disable iff (reset_i)
		up_take && up_free && up_in_frame_i.tgt.slot == q.slot && up_in_frame_i.tgt.fpga == q.fpga
		|=> !q.up_v || $past(txf_take);
	endproperty
	a_stop_at_target: assert property (p_stop_at_target) else $error("unicast passed its target");

	property p_one_way;
		@(posedge clk_i) disable iff (reset_i)
		txf_take && !tx_bcast && !up_take && !dn_take && up_free && dn_free
		|=> $onehot({q.up_v, q.dn_v});
	endproperty
	a_one_way: assert property (p_one_way) else $error("unicast sent in both directions");

	property p_id_stable;
		@(posedge clk_i) disable iff (reset_i)
		q.id_ok |=> $stable(q.slot) && $stable(q.fpga);
	endproperty
	a_id_stable: assert property (p_id_stable) else $error("own indices changed");
endmodule
`default_nettype wire

// >>> tb/fre_ring_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// ring neighbours: take words leaving the endpoint
// ************************************************************
module fre_ring_model (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	// pace control, high for a stalling ring
	input  wire logic                slow_i,
	// words leaving upward
	input  wire logic                up_valid_i,
	output logic                     up_ready_o,
	input  wire fre_pkg::fre_frame_t up_frame_i,
	// words leaving downward
	input  wire logic                dn_valid_i,
	output logic                     dn_ready_o,
	input  wire fre_pkg::fre_frame_t dn_frame_i
);
	logic [3:0]          pace_q = 4'h1; // stall pattern
	fre_pkg::fre_frame_t up_q[$];       // words taken upward
	fre_pkg::fre_frame_t dn_q[$];       // words taken downward
	always @(posedge clk_i) begin
		if (!reset_i && up_valid_i && up_ready_o) begin
			up_q.push_back(up_frame_i);
		end
		if (!reset_i && dn_valid_i && dn_ready_o) begin
			dn_q.push_back(dn_frame_i);
		end
	end
	// readies move only after the falling edge
	always @(negedge clk_i) begin
		pace_q     <= {pace_q[2:0], pace_q[3] ^ pace_q[2]};
		up_ready_o <= !slow_i || pace_q[0];
		dn_ready_o <= !slow_i || pace_q[1];
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [3:0] MY_SLOT = 4'h1; // own card strap
	localparam logic [3:0] MY_FPGA = 4'h3; // own device strap
	logic clk = 1'b0, reset = 1'b1, hold = 1'b0, slow = 1'b0, rx_rdy = 1'b0;
	logic up_v = 1'b0, dn_v = 1'b0, tx_v = 1'b0;
	logic up_rdy, dn_rdy, tx_rdy, rx_v, up_ov, dn_ov;
	wire ring_up_rdy, ring_dn_rdy;
	logic [1:0] rdy_cnt = 2'h0;
	fre_pkg::fre_frame_t up_f = '0, dn_f = '0, tx_f = '0, up_of, dn_of;
	wire fre_pkg::fre_rx_t rx_w;
	fre_pkg::fre_frame_t eu[$], ed[$]; // expected ring words
	fre_pkg::fre_rx_t er[$], rx_q[$];  // expected and seen deliveries
	logic [31:0] seed = 32'h00012AED;
	int bad_count = 0, num_checks = 0;
	always #5 clk = ~clk;
	fre_endpoint DUT (.clk_i(clk), .reset_i(reset), .my_slot_i(MY_SLOT), .my_fpga_i(MY_FPGA),
		.up_in_valid_i(up_v), .up_in_ready_o(up_rdy), .up_in_frame_i(up_f),
		.dn_in_valid_i(dn_v), .dn_in_ready_o(dn_rdy), .dn_in_frame_i(dn_f),
		.up_out_valid_o(up_ov), .up_out_ready_i(ring_up_rdy), .up_out_frame_o(up_of),
		.dn_out_valid_o(dn_ov), .dn_out_ready_i(ring_dn_rdy), .dn_out_frame_o(dn_of),
		.rx_valid_o(rx_v), .rx_ready_i(rx_rdy), .rx_src_slot_o(rx_w.src.slot),
		.rx_src_fpga_o(rx_w.src.fpga), .rx_src_cmd_o(rx_w.src.cmd), .rx_src_reg_o(rx_w.src.rg),
		.rx_tgt_cmd_o(rx_w.tgt_cmd), .rx_tgt_reg_o(rx_w.tgt_rg), .rx_data_o(rx_w.data),
		.tx_valid_i(tx_v), .tx_ready_o(tx_rdy), .tx_tgt_slot_i(tx_f.tgt.slot),
		.tx_tgt_fpga_i(tx_f.tgt.fpga), .tx_tgt_cmd_i(tx_f.tgt.cmd), .tx_tgt_reg_i(tx_f.tgt.rg),
		.tx_src_cmd_i(tx_f.src.cmd), .tx_src_reg_i(tx_f.src.rg), .tx_data_i(tx_f.data));
	fre_ring_model ring (.clk_i(clk), .reset_i(reset), .slow_i(slow),
		.up_valid_i(up_ov), .up_ready_o(ring_up_rdy), .up_frame_i(up_of),
		.dn_valid_i(dn_ov), .dn_ready_o(ring_dn_rdy), .dn_frame_i(dn_of));
	// user side takes words on most cycles unless held
	always @(posedge clk) begin
		if (rx_v && rx_rdy) begin
			rx_q.push_back(rx_w);
		end
	end
	always @(negedge clk) begin
		rdy_cnt <= rdy_cnt + 2'h1;
		rx_rdy  <= !hold && (rdy_cnt != 2'h0);
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// random word from the own card, origin device sf
	function automatic fre_pkg::fre_frame_t mkf(logic [3:0] ts, logic [3:0] tf, logic [3:0] sf);
		fre_pkg::fre_frame_t f;
		f.data = {rnd(), rnd()};
		f.tgt = '{ts, tf, seed[0], seed[15:8]};
		f.src = '{MY_SLOT, sf, seed[1], seed[23:16]};
		return f;
	endfunction
	// what the user should see; host origin hides command and register
	function automatic fre_pkg::fre_rx_t exp_rx(fre_pkg::fre_frame_t f);
		fre_pkg::fre_rx_t r;
		r = '{f.src, f.tgt.cmd, f.tgt.rg, f.data};
		if (int'(f.src.fpga) >= fre_pkg::FPGA_COUNT || f.src.slot != MY_SLOT) begin
			r.src.cmd = fre_pkg::CMD_WR;
			r.src.rg = fre_pkg::HOST_SRC_REG;
		end
		return r;
	endfunction
	task automatic chk_frame(input string n, input fre_pkg::fre_frame_t e, input fre_pkg::fre_frame_t g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rx(input string n, input fre_pkg::fre_rx_t e, input fre_pkg::fre_rx_t g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_num(input string n, input int e, input int g);
		num_checks++;
		if (g != e) begin
			bad_count++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	// offer one word: sel 0 up input, 1 down input, 2 user send
	task automatic send(input logic [1:0] sel, input fre_pkg::fre_frame_t f, output logic ok);
		int n;
		n = 0;
		@(negedge clk);
		up_v = (sel == 2'h0);
		dn_v = (sel == 2'h1);
		tx_v = (sel == 2'h2);
		if (sel == 2'h0) up_f = f;
		if (sel == 2'h1) dn_f = f;
		if (sel == 2'h2) tx_f = f;
		#1;
		while ((sel == 2'h0 ? up_rdy : sel == 2'h1 ? dn_rdy : tx_rdy) !== 1'b1 && n < 40) begin
			@(negedge clk);
			#1;
			n++;
		end
		ok = (n < 40);
		if (ok) @(posedge clk);
	endtask
	// release all requests, stale data inverted
	task automatic idle();
		@(negedge clk);
		{up_v, dn_v, tx_v} = 3'h0;
		up_f = ~up_f;
		dn_f = ~dn_f;
		tx_f = ~tx_f;
	endtask
	// wait for all expected words, then compare in order
	task automatic settle(input string name);
		int n;
		n = 0;
		idle();
		while ((rx_q.size() < er.size() || ring.up_q.size() < eu.size()
			|| ring.dn_q.size() < ed.size()) && n < 600) begin
			@(negedge clk);
			n++;
		end
		repeat (6) @(negedge clk);
		chk_num("delivered count", er.size(), rx_q.size());
		chk_num("upward count", eu.size(), ring.up_q.size());
		chk_num("downward count", ed.size(), ring.dn_q.size());
		foreach (er[i]) if (i < rx_q.size()) chk_rx("delivered word", er[i], rx_q[i]);
		foreach (eu[i]) if (i < ring.up_q.size()) chk_frame("up word", eu[i], ring.up_q[i]);
		foreach (ed[i]) if (i < ring.dn_q.size()) chk_frame("down word", ed[i], ring.dn_q[i]);
		er.delete();
		rx_q.delete();
		eu.delete();
		ed.delete();
		ring.up_q.delete();
		ring.dn_q.delete();
		$display("test %s done", name);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
	initial begin
		logic ok;
		int taken;
		logic [3:0] t;
		fre_pkg::fre_frame_t f;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		// host read request on the down input
		f = mkf(MY_SLOT, MY_FPGA, 4'h8);
		f.tgt.cmd = fre_pkg::CMD_RD;
		f.src = '{MY_SLOT, 4'h8, fre_pkg::CMD_RD, 8'h5A};
		send(2'h1, f, ok);
		er.push_back(exp_rx(f));
		settle("host read");
		// host broadcast ends here, peer broadcast and multicast travel on
		f = mkf(4'hF, 4'hF, 4'h8);
		send(2'h0, f, ok);
		er.push_back(exp_rx(f));
		f = mkf(MY_SLOT, 4'hF, 4'h1);
		send(2'h0, f, ok);
		er.push_back(exp_rx(f));
		eu.push_back(f);
		f = mkf(4'hF, MY_FPGA, 4'h1);
		send(2'h0, f, ok);
		er.push_back(exp_rx(f));
		eu.push_back(f);
		settle("broadcast");
		// words for others pass straight through
		f = mkf(MY_SLOT, 4'h6, 4'h1);
		send(2'h0, f, ok);
		eu.push_back(f);
		f = mkf(MY_SLOT, 4'h0, 4'h8);
		send(2'h1, f, ok);
		ed.push_back(f);
		settle("pass through");
		// user stalls until the buffer refuses, then drains
		hold = 1'b1;
		taken = 0;
		ok = 1'b1;
		while (ok && taken < 12) begin
			f = mkf(MY_SLOT, MY_FPGA, {3'h0, seed[4]});
			send(2'h0, f, ok);
			if (ok) begin
				taken++;
				er.push_back(exp_rx(f));
			end
		end
		idle();
		chk_num("held before refusal", fre_pkg::FIFO_DEPTH + 1, taken);
		hold = 1'b0;
		settle("fill and drain");
		// user sends against a stalling ring
		slow = 1'b1;
		for (int i = 0; i < 15; i++) begin
			t = (i == 0) ? 4'h8 : (i == 1) ? 4'hF : 4'(rnd() % 8);
			if (t == MY_FPGA) t = 4'h7;
			f = mkf(MY_SLOT, t, MY_FPGA);
			send(2'h2, f, ok);
			chk_num("user send taken", 1, int'(ok));
			if (t == 4'hF || (t + 4'h6) % 9 <= (4'hC - t) % 9) eu.push_back(f);
			if (t == 4'hF || (t + 4'h6) % 9 > (4'hC - t) % 9) ed.push_back(f);
		end
		settle("user send");
		complete_run();
	end
endmodule
`default_nettype wire
